// file: core/pis_pkg.sv
// package for the transceiver interrupt, status and test register bank
// assumes a 5-bit register index on the management port and 16-bit data
package pis_pkg;
    localparam logic [4:0] ADDR_IRQ = 5'h11;
    localparam logic [4:0] ADDR_STAT = 5'h12;
    localparam logic [4:0] ADDR_TEST = 5'h13;
    // interrupt register fields
    localparam int IRQ_PDF_EN_BIT = 12;
    localparam int IRQ_LF_EN_BIT = 10;
    localparam int IRQ_AN_EN_BIT = 8;
    localparam int IRQ_PDF_FLAG_BIT = 4;
    localparam int IRQ_LF_FLAG_BIT = 2;
    localparam int IRQ_AN_FLAG_BIT = 0;
    // status register fields
    localparam int STAT_DUPLEX_BIT = 11;
    localparam int STAT_SPEED_BIT = 10;
    localparam int STAT_ADDR_LSB = 0;
    // test register fields
    localparam int TEST_CLK_LSB = 14;
    localparam int TEST_SHAPER_LSB = 12;
    localparam int TEST_NO_PD_BIT = 7;
    localparam int TEST_MAN_PD_BIT = 6;
    localparam int TEST_FAST_DESC_BIT = 3;
    localparam int TEST_LOOP_BIT = 2;
    // writable masks and reset values: reserved bits never stored
    localparam logic [15:0] IRQ_EN_MASK = 16'h1500;
    localparam logic [15:0] IRQ_FLAG_MASK = 16'h0015;
    localparam logic [15:0] TEST_MASK = 16'hF0CC;
    localparam logic [15:0] TEST_RESET = 16'h0004;
    localparam logic [4:0] ADDR_RESET = 5'h00;
    localparam logic [15:0] ZERO16 = 16'h0000;

    typedef struct packed {
        logic par_detect_fault;
        logic link_fail;
        logic autoneg_done;
    } pis_event_type;

    typedef struct packed {
        logic [1:0] clk_src_sel;
        logic [1:0] line_shaper_sel;
        logic force_stay_powered;
        logic manual_powerdown_en;
        logic fast_descrambler_lock;
        logic digital_loopback_en;
    } pis_test_type;

    typedef enum logic [1:0] {
        SHAPER_NORMAL = 2'b00,
        SHAPER_NRZ_INT = 2'b01,
        SHAPER_NRZ_EXT_A = 2'b10,
        SHAPER_NRZ_EXT_B = 2'b11
    } pis_shaper_type;
endpackage

// file: core/pis_flag.sv
// one sticky event flag, write-one-to-clear
// assumes event and clear strobes are synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module pis_flag (
    input wire logic mclk,
    input wire logic rst,
    input wire logic set_in,
    input wire logic clr_in,
    output var logic flag
);
    logic flag_next;

    // set wins over a clear in the same cycle so no event is lost
    always_comb begin
        flag_next = flag;
        if (clr_in) begin
            flag_next = 1'b0;
        end
        if (set_in) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flag <= 1'b0;
        end else begin
            flag <= flag_next;
        end
    end
endmodule
`default_nettype wire

// file: core/pis_rdmux.sv
// read-data selection for the three registers
// assumes unmapped indices read as zero
`timescale 1ns/1ps
`default_nettype none
module pis_rdmux
    import pis_pkg::*;
(
    input wire logic [4:0] addr,
    input wire logic [15:0] irq_word,
    input wire logic [15:0] stat_word,
    input wire logic [15:0] test_word,
    output var logic [15:0] rdata
);
    always_comb begin
        case (addr)
            ADDR_IRQ: rdata = irq_word;
            ADDR_STAT: rdata = stat_word;
            ADDR_TEST: rdata = test_word;
            default: rdata = ZERO16;
        endcase
    end
endmodule
`default_nettype wire

// file: core/pis_regs.sv
// interrupt, link status and test/power control registers of the transceiver
// assumes register port and event inputs are synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module pis_regs (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output var logic [15:0] reg_rdata,
    input wire pis_pkg::pis_event_type event_in,
    input wire logic link_up,
    input wire logic link_full_duplex,
    input wire logic link_speed_100,
    input wire logic [4:0] strap_address,
    input wire logic irq_active_high,
    output var logic irq_pin,
    output var pis_pkg::pis_test_type test_ctrl,
    output var logic powerdown_effective
);
    import pis_pkg::*;

    logic [15:0] irq_en_reg;
    logic [15:0] irq_en_next;
    pis_test_type test_reg;
    pis_test_type test_next;
    logic [15:0] test_word;
    logic duplex_reg;
    logic duplex_next;
    logic speed_reg;
    logic speed_next;
    logic [4:0] addr_reg;
    logic [4:0] addr_next;
    logic strap_taken_reg;
    logic strap_taken_next;
    logic [15:0] rdata_next;
    logic [15:0] rdata_comb;
    logic irq_pin_next;
    logic pd_next;
    logic wr_irq;
    logic wr_test;
    logic [2:0] flags;
    logic [15:0] irq_word;
    logic [15:0] stat_word;
    logic irq_any;

    function automatic logic w1c(input logic [15:0] d, input int b);
        return d[b];
    endfunction

    assign wr_irq = reg_wr && (reg_addr == ADDR_IRQ);
    assign wr_test = reg_wr && (reg_addr == ADDR_TEST);

    pis_flag u_flag_pdf (
        .mclk(mclk),
        .rst(rst),
        .set_in(event_in.par_detect_fault),
        .clr_in(wr_irq && w1c(reg_wdata, IRQ_PDF_FLAG_BIT)),
        .flag(flags[2])
    );
    pis_flag u_flag_lf (
        .mclk(mclk),
        .rst(rst),
        .set_in(event_in.link_fail),
        .clr_in(wr_irq && w1c(reg_wdata, IRQ_LF_FLAG_BIT)),
        .flag(flags[1])
    );
    pis_flag u_flag_an (
        .mclk(mclk),
        .rst(rst),
        .set_in(event_in.autoneg_done),
        .clr_in(wr_irq && w1c(reg_wdata, IRQ_AN_FLAG_BIT)),
        .flag(flags[0])
    );

    // enables and test register keep only documented bits
    always_comb begin
        irq_en_next = irq_en_reg;
        test_next = test_reg;
        if (wr_irq) begin
            irq_en_next = reg_wdata & IRQ_EN_MASK;
        end
        if (wr_test) begin
            test_next.clk_src_sel = reg_wdata[TEST_CLK_LSB +: 2];
            test_next.line_shaper_sel = reg_wdata[TEST_SHAPER_LSB +: 2];
            test_next.force_stay_powered = reg_wdata[TEST_NO_PD_BIT];
            test_next.manual_powerdown_en = reg_wdata[TEST_MAN_PD_BIT];
            test_next.fast_descrambler_lock = reg_wdata[TEST_FAST_DESC_BIT];
            test_next.digital_loopback_en = reg_wdata[TEST_LOOP_BIT];
        end
    end

    // link result status; duplex reads 0 while link is down
    always_comb begin
        duplex_next = link_up && link_full_duplex;
        speed_next = link_speed_100;
        strap_taken_next = 1'b1;
        addr_next = addr_reg;
        // address caught once after reset release, never from the async branch
        if (!strap_taken_reg) begin
            addr_next = strap_address;
        end
    end

    always_comb begin
        irq_word = ZERO16;
        irq_word = irq_en_reg & IRQ_EN_MASK;
        irq_word[IRQ_PDF_FLAG_BIT] = flags[2];
        irq_word[IRQ_LF_FLAG_BIT] = flags[1];
        irq_word[IRQ_AN_FLAG_BIT] = flags[0];
        stat_word = ZERO16;
        stat_word[STAT_DUPLEX_BIT] = duplex_reg;
        stat_word[STAT_SPEED_BIT] = speed_reg;
        stat_word[STAT_ADDR_LSB +: 5] = addr_reg;
        test_word = ZERO16;
        test_word[TEST_CLK_LSB +: 2] = test_reg.clk_src_sel;
        test_word[TEST_SHAPER_LSB +: 2] = test_reg.line_shaper_sel;
        test_word[TEST_NO_PD_BIT] = test_reg.force_stay_powered;
        test_word[TEST_MAN_PD_BIT] = test_reg.manual_powerdown_en;
        test_word[TEST_FAST_DESC_BIT] = test_reg.fast_descrambler_lock;
        test_word[TEST_LOOP_BIT] = test_reg.digital_loopback_en;
    end

    pis_rdmux u_rdmux (
        .addr(reg_addr),
        .irq_word(irq_word),
        .stat_word(stat_word),
        .test_word(test_word),
        .rdata(rdata_comb)
    );

    // interrupt and power outputs; pin level follows polarity select
    always_comb begin
        irq_any = (flags[2] && irq_en_reg[IRQ_PDF_EN_BIT])
            || (flags[1] && irq_en_reg[IRQ_LF_EN_BIT])
            || (flags[0] && irq_en_reg[IRQ_AN_EN_BIT]);
        irq_pin_next = irq_active_high ? irq_any : !irq_any;
        // stay-powered overrides any manual power-down request
        pd_next = test_reg.manual_powerdown_en && !test_reg.force_stay_powered;
        rdata_next = reg_rd ? rdata_comb : ZERO16;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_en_reg <= ZERO16;
            test_reg <= '{2'b00, 2'b00, 1'b0, 1'b0, 1'b0, 1'b1};
            duplex_reg <= 1'b0;
            speed_reg <= 1'b0;
            addr_reg <= ADDR_RESET;
            strap_taken_reg <= 1'b0;
            reg_rdata <= ZERO16;
            // pin reset level assumes select low, i.e. active low idle high
            irq_pin <= 1'b1;
            test_ctrl <= '{2'b00, 2'b00, 1'b0, 1'b0, 1'b0, 1'b1};
            powerdown_effective <= 1'b0;
        end else begin
            irq_en_reg <= irq_en_next;
            test_reg <= test_next;
            duplex_reg <= duplex_next;
            speed_reg <= speed_next;
            addr_reg <= addr_next;
            strap_taken_reg <= strap_taken_next;
            reg_rdata <= rdata_next;
            irq_pin <= irq_pin_next;
            test_ctrl <= test_reg;
            powerdown_effective <= pd_next;
        end
    end
endmodule
`default_nettype wire

// file: testbench/pis_regs_properties.sv
// port-level checks for the interrupt, status and test register bank
// assumes binding to pis_regs; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module pis_regs_checker
    import pis_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire pis_event_type event_in,
    input wire logic link_up,
    input wire logic link_full_duplex,
    input wire logic link_speed_100,
    input wire logic [4:0] strap_address,
    input wire logic irq_active_high,
    input wire logic irq_pin,
    input wire pis_test_type test_ctrl,
    input wire logic powerdown_effective
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_rd_idle_zero: assert property (!reg_rd |=> reg_rdata == ZERO16)
        else $error("read data not zero while idle");
    a_unmapped_zero: assert property ((reg_rd && (reg_addr < ADDR_IRQ || reg_addr > ADDR_TEST)) |=> reg_rdata == ZERO16)
        else $error("unmapped read not zero");
    a_irq_reserved_zero: assert property ((reg_rd && reg_addr == ADDR_IRQ) |=> (reg_rdata & ~(IRQ_EN_MASK | IRQ_FLAG_MASK)) == ZERO16)
        else $error("interrupt reserved bits not zero");
    a_irq_en_readback: assert property ((reg_wr && reg_addr == ADDR_IRQ ##1 reg_rd && reg_addr == ADDR_IRQ) |=> (reg_rdata & IRQ_EN_MASK) == ($past(reg_wdata, 2) & IRQ_EN_MASK))
        else $error("interrupt enables not read back");
    a_test_readback: assert property ((reg_wr && reg_addr == ADDR_TEST ##1 reg_rd && reg_addr == ADDR_TEST) |=> reg_rdata == ($past(reg_wdata, 2) & TEST_MASK))
        else $error("test register not read back");
    // controls lag the register by one more cycle
    a_test_ctrl_follow: assert property ((reg_wr && reg_addr == ADDR_TEST) |=> ##1 {test_ctrl[7:4], 4'h0, test_ctrl[3:2], 2'h0, test_ctrl[1:0], 2'h0} == ($past(reg_wdata, 2) & TEST_MASK))
        else $error("test controls do not follow write");
    a_flag_latched: assert property ((reg_rd && reg_addr == ADDR_IRQ && !$past(rst) && $past(event_in.link_fail)) |=> reg_rdata[IRQ_LF_FLAG_BIT])
        else $error("link fail flag not latched");
    a_status_link: assert property ((reg_rd && reg_addr == ADDR_STAT && !$past(rst) && $stable(link_up) && $stable(link_full_duplex) && $stable(link_speed_100)) |=> reg_rdata[11:10] == {$past(link_up) & $past(link_full_duplex), $past(link_speed_100)})
        else $error("duplex or speed status wrong");
    // stable controls hide any lag between the two outputs
    a_stay_powered: assert property ((test_ctrl.force_stay_powered && $stable(test_ctrl)) |-> !powerdown_effective)
        else $error("power down despite force stay powered");
    a_manual_pd: assert property ((test_ctrl.manual_powerdown_en && !test_ctrl.force_stay_powered && $stable(test_ctrl)) |-> powerdown_effective)
        else $error("manual power down not effective");
endmodule
bind pis_regs pis_regs_checker u_chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_in(event_in), .link_up(link_up),
    .link_full_duplex(link_full_duplex), .link_speed_100(link_speed_100), .strap_address(strap_address),
    .irq_active_high(irq_active_high), .irq_pin(irq_pin), .test_ctrl(test_ctrl), .powerdown_effective(powerdown_effective));
`default_nettype wire

// file: testbench/test_pis_regs.sv
// self-checking bench for the interrupt, status and test register bank
// assumes the package and pis_regs are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_pis_regs;
    import pis_pkg::*;
    typedef struct packed {logic [4:0] a; logic [15:0] w; logic [15:0] e;} pis_row_type;
    logic mclk, rst, reg_wr, reg_rd, link_up, link_full_duplex, link_speed_100, irq_active_high, irq_pin, pd;
    logic [4:0] reg_addr, strap_address;
    logic [15:0] reg_wdata, reg_rdata;
    pis_event_type event_in;
    pis_test_type test_ctrl;
    int err_count, checks;
    pis_row_type rows [9] = '{'{ADDR_IRQ, 16'hFFFF, 16'h1500}, '{ADDR_IRQ, 16'h0000, 16'h0000},
        '{ADDR_TEST, 16'hFFFF, 16'hF0CC}, '{ADDR_TEST, 16'h1000, 16'h1000}, '{ADDR_TEST, 16'h2008, 16'h2008},
        '{ADDR_TEST, 16'h3040, 16'h3040}, '{ADDR_TEST, 16'hC080, 16'hC080}, '{ADDR_STAT, 16'hFFFF, 16'h0C15},
        '{5'h1F, 16'hFFFF, 16'h0000}};
    pis_regs DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_in(event_in), .link_up(link_up),
        .link_full_duplex(link_full_duplex), .link_speed_100(link_speed_100), .strap_address(strap_address),
        .irq_active_high(irq_active_high), .irq_pin(irq_pin), .test_ctrl(test_ctrl), .powerdown_effective(pd));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata, e);
    endtask
    // write then read back with no gap, so the readback properties see their sequence
    task automatic wrrd(input logic [4:0] a, input logic [15:0] d, input logic [15:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata, e);
    endtask
    // pin settles one edge after the flag
    task automatic pulse(input int i);
        @(posedge mclk);
        event_in <= pis_event_type'(3'b001 << i);
        @(posedge mclk);
        event_in <= '0;
        @(posedge mclk);
        #1;
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        complete_run();
    end
    initial begin
        {rst, reg_addr, reg_wdata, reg_wr, reg_rd, event_in} = {1'b1, 26'h0};
        {link_up, link_full_duplex, link_speed_100, irq_active_high, strap_address} = {4'hF, 5'h15};
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd(ADDR_TEST, TEST_RESET);
        rd(ADDR_IRQ, ZERO16);
        foreach (rows[n]) begin
            wrrd(rows[n].a, rows[n].w, rows[n].e);
        end
        wr(ADDR_IRQ, IRQ_EN_MASK);
        for (int i = 0; i < 3; i++) begin
            pulse(i);
            cmp({15'h0, irq_pin}, 16'h0001);
            @(posedge mclk) irq_active_high <= 1'b0;
            repeat (2) @(posedge mclk);
            #1 cmp({15'h0, irq_pin}, 16'h0000);
            @(posedge mclk) irq_active_high <= 1'b1;
            rd(ADDR_IRQ, IRQ_EN_MASK | (16'h0001 << (2 * i)));
            wr(ADDR_IRQ, IRQ_EN_MASK);
            rd(ADDR_IRQ, IRQ_EN_MASK | (16'h0001 << (2 * i)));
            wr(ADDR_IRQ, IRQ_EN_MASK | (16'h0001 << (2 * i)));
            @(posedge mclk);
            #1 cmp({15'h0, irq_pin}, 16'h0000);
            rd(ADDR_IRQ, IRQ_EN_MASK);
        end
        wr(ADDR_IRQ, ZERO16);
        pulse(1);
        cmp({15'h0, irq_pin}, 16'h0000);
        rd(ADDR_IRQ, 16'h0004);
        // clear and event in one cycle: the event must win, read straight behind it
        @(posedge mclk);
        reg_addr <= ADDR_IRQ;
        reg_wdata <= 16'h0004;
        reg_wr <= 1'b1;
        event_in <= pis_event_type'(3'b010);
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        event_in <= '0;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata, 16'h0004);
        @(posedge mclk) link_up <= 1'b0;
        rd(ADDR_STAT, 16'h0415);
        @(posedge mclk) link_speed_100 <= 1'b0;
        rd(ADDR_STAT, 16'h0015);
        // reset in mid-run: flags, test bits and the strap capture start over
        @(posedge mclk) rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(ADDR_TEST, TEST_RESET);
        rd(ADDR_IRQ, ZERO16);
        rd(ADDR_STAT, 16'h0015);
        complete_run();
    end
endmodule
`default_nettype wire
